// File: rtl/supply_monitor.sv
// Behaviour
// - With sleep clock stop set, monitor halts in sleep, keeping state.
// - With debug run 0, monitor halts in debug, keeping state.
// - With debug run 1, monitor keeps running in debug.
// - Detection result reads 1 below threshold, 0 at or above.
// - Mode 0 runs continuously, updating the result every detector tick.
// - Continuous low result sets the flag, and also resets with key 0xa.
// - Modes 1 to 3 power the comparator periodically and sample once.
// - Intermittent events need the selected count of successive lows.
// - Key exactly 0xa selects reset; anything else selects the interrupt.
// - Writing 1 clears the flag; writing 0 does nothing.
// - Interrupt request is high only while flag and enable are both set.
// - The flag stays set after the supply recovers until cleared.
// - Reset is issued at the moment the flag would be set.
// - After reset, run continuous; release reset when result returns 0.
// - Reset state restores clock fields, clears mode, count, irq enable.
// - Mode 0 is continuous; 1, 2, 3 divide the detector clock by 128/256/512.
// - Low count 0 to 3 needs 1, 2, 4 or 8 lows; ignored when continuous.
`timescale 1ns/10ps
`default_nettype none
module supply_monitor #(
    parameter int TIMER_WIDTH = 9
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clockEnable,
    input wire logic detectorTick,
    input wire logic comparatorLow,
    input wire logic sleepMode,
    input wire logic sleepClockStop,
    input wire logic debugMode,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic comparatorPower,
    output logic [4:0] thresholdLevel,
    output logic [1:0] clockSourceSelect,
    output logic [2:0] clockDividerSelect,
    output logic irqRequest,
    output logic resetRequest
);
    typedef struct packed {
        logic awHave;
        logic wHave;
        logic [7:0] wAddr;
        logic [15:0] wData;
        logic [1:0] wStrb;
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [1:0] rResp;
        logic [15:0] rData;
        logic [15:0] protKey;
        logic debugRun;
        logic [2:0] clock_divider_select;
        logic [1:0] clock_source_select;
        logic [1:0] lowSel;
        logic [4:0] thresh;
        logic [3:0] rstKey;
        logic [1:0] mode;
        logic enable;
        logic result;
        logic flag;
        logic irqEn;
        logic [3:0] lowCnt;
        logic rstAct;
        logic power;
        logic irq;
        logic rstReq;
    } state_type;

    state_type st_q;
    state_type st_d;
    logic run;
    logic doWrite;
    logic unlocked;
    logic flagClr;
    logic cfgChange;
    logic lowEvent;
    logic contMode;
    logic timerClear;
    logic [3:0] need;
    logic [15:0] wv;
    logic [TIMER_WIDTH-1:0] limit;
    logic [TIMER_WIDTH-1:0] tCount;
    logic wrap;

    function automatic logic [15:0] readVal(input state_type s,
                                            input logic [7:0] a);
        logic [15:0] v;
        v = '0;
        case (a)
            supply_monitor_pkg::ADDR_PROTECT: v = s.protKey;
            supply_monitor_pkg::ADDR_CLOCK: begin
                v[supply_monitor_pkg::DEBUG_RUN_BIT] = s.debugRun;
                v[supply_monitor_pkg::CLK_DIV_LSB +: 3] = s.clock_divider_select;
                v[supply_monitor_pkg::CLK_SRC_LSB +: 2] = s.clock_source_select;
            end
            supply_monitor_pkg::ADDR_CONTROL: begin
                v[supply_monitor_pkg::LOW_SEL_LSB +: 2] = s.lowSel;
                v[supply_monitor_pkg::THRESH_LSB +: 5] = s.thresh;
                v[supply_monitor_pkg::RST_KEY_LSB +: 4] = s.rstKey;
                v[supply_monitor_pkg::MODE_LSB +: 2] = s.mode;
                v[supply_monitor_pkg::ENABLE_BIT] = s.enable;
            end
            supply_monitor_pkg::ADDR_STATUS: begin
                v[supply_monitor_pkg::RESULT_BIT] = s.result;
                v[supply_monitor_pkg::FLAG_BIT] = s.flag;
            end
            supply_monitor_pkg::ADDR_IRQ_EN: begin
                v[supply_monitor_pkg::IRQ_EN_BIT] = s.irqEn;
            end
            default: v = '0;
        endcase
        return v;
    endfunction : readVal

    function automatic logic mapped(input logic [7:0] a);
        return a == supply_monitor_pkg::ADDR_PROTECT
            || a == supply_monitor_pkg::ADDR_CLOCK
            || a == supply_monitor_pkg::ADDR_CONTROL
            || a == supply_monitor_pkg::ADDR_STATUS
            || a == supply_monitor_pkg::ADDR_IRQ_EN;
    endfunction : mapped

    period_timer #(
        .WIDTH(TIMER_WIDTH)
    ) intervalTimer (
        .clock(clock),
        .reset_n(reset_n),
        .clockEnable(clockEnable),
        .tick(run),
        .clear(timerClear),
        .limit(limit),
        .count(tCount),
        .wrap(wrap)
    );

    always_comb begin
        st_d = st_q;
        // The detector clock is gated, so a halted monitor keeps all state.
        run = detectorTick && !(sleepMode && sleepClockStop)
            && !(debugMode && !st_q.debugRun);
        unlocked = st_q.protKey == supply_monitor_pkg::UNLOCK_KEY;
        if (bready && st_q.bValid) begin
            st_d.bValid = 1'b0;
        end
        if (awvalid && st_q.awReady) begin
            st_d.awHave = 1'b1;
            st_d.wAddr = awaddr[7:0];
        end
        if (wvalid && st_q.wReady) begin
            st_d.wHave = 1'b1;
            st_d.wData = wdata[15:0];
            st_d.wStrb = wstrb[1:0];
        end
        doWrite = st_q.awHave && st_q.wHave && !st_q.bValid;
        wv = readVal(st_q, st_q.wAddr);
        if (st_q.wStrb[0]) begin
            wv[7:0] = st_q.wData[7:0];
        end
        if (st_q.wStrb[1]) begin
            wv[15:8] = st_q.wData[15:8];
        end
        flagClr = 1'b0;
        if (doWrite) begin
            st_d.awHave = 1'b0;
            st_d.wHave = 1'b0;
            st_d.bValid = 1'b1;
            st_d.bResp = mapped(st_q.wAddr) ? supply_monitor_pkg::RESP_OKAY
                                            : supply_monitor_pkg::RESP_SLVERR;
            case (st_q.wAddr)
                supply_monitor_pkg::ADDR_PROTECT: st_d.protKey = wv;
                supply_monitor_pkg::ADDR_CLOCK: begin
                    if (unlocked) begin
                        st_d.debugRun = wv[supply_monitor_pkg::DEBUG_RUN_BIT];
                        st_d.clock_divider_select = wv[supply_monitor_pkg::CLK_DIV_LSB +: 3];
                        st_d.clock_source_select = wv[supply_monitor_pkg::CLK_SRC_LSB +: 2];
                    end
                end
                supply_monitor_pkg::ADDR_CONTROL: begin
                    if (unlocked) begin
                        st_d.thresh = wv[supply_monitor_pkg::THRESH_LSB +: 5];
                        st_d.rstKey = wv[supply_monitor_pkg::RST_KEY_LSB +: 4];
                        st_d.mode = wv[supply_monitor_pkg::MODE_LSB +: 2];
                        st_d.enable = wv[supply_monitor_pkg::ENABLE_BIT];
                        // The count only matters once intermittent, so it
                        // only latches while the monitor is intermittent.
                        if (st_q.mode != supply_monitor_pkg::MODE_CONTINUOUS)
                        begin
                            st_d.lowSel =
                                wv[supply_monitor_pkg::LOW_SEL_LSB +: 2];
                        end
                    end
                end
                supply_monitor_pkg::ADDR_STATUS: begin
                    flagClr = st_q.wStrb[0]
                        && st_q.wData[supply_monitor_pkg::FLAG_BIT];
                end
                supply_monitor_pkg::ADDR_IRQ_EN: begin
                    if (unlocked) begin
                        st_d.irqEn = wv[supply_monitor_pkg::IRQ_EN_BIT];
                    end
                end
                default: st_d.bResp = supply_monitor_pkg::RESP_SLVERR;
            endcase
        end
        cfgChange = st_q.enable && ({st_d.lowSel, st_d.rstKey, st_d.mode}
            != {st_q.lowSel, st_q.rstKey, st_q.mode});
        if (rready && st_q.rValid) begin
            st_d.rValid = 1'b0;
        end
        if (arvalid && st_q.arReady) begin
            st_d.rValid = 1'b1;
            st_d.rData = readVal(st_q, araddr[7:0]);
            st_d.rResp = mapped(araddr[7:0]) ? supply_monitor_pkg::RESP_OKAY
                                             : supply_monitor_pkg::RESP_SLVERR;
        end
        contMode = st_q.mode == supply_monitor_pkg::MODE_CONTINUOUS
            || st_q.rstAct;
        case (st_q.mode)
            supply_monitor_pkg::MODE_PER_128:
                limit = supply_monitor_pkg::LIMIT_128;
            supply_monitor_pkg::MODE_PER_256:
                limit = supply_monitor_pkg::LIMIT_256;
            default: limit = supply_monitor_pkg::LIMIT_512;
        endcase
        need = supply_monitor_pkg::ONE_LOW << st_q.lowSel;
        timerClear = !st_q.enable || contMode || cfgChange;
        lowEvent = 1'b0;
        if (!st_q.enable) begin
            st_d.power = 1'b0;
            st_d.lowCnt = '0;
        end else if (contMode) begin
            st_d.power = 1'b1;
            st_d.lowCnt = '0;
            if (run) begin
                st_d.result = comparatorLow;
                lowEvent = comparatorLow;
            end
        end else begin
            // Power only for the last few ticks of each interval to save
            // current while still letting the comparator settle.
            st_d.power = tCount >= limit - supply_monitor_pkg::WARM_TICKS;
            if (wrap) begin
                st_d.result = comparatorLow;
                if (!comparatorLow) begin
                    st_d.lowCnt = '0;
                end else if (st_q.lowCnt == need - 4'h1) begin
                    lowEvent = 1'b1;
                    st_d.lowCnt = '0;
                end else begin
                    st_d.lowCnt = st_q.lowCnt + 4'h1;
                end
            end
        end
        if (cfgChange) begin
            st_d.lowCnt = '0;
        end
        if (flagClr) begin
            st_d.flag = 1'b0;
        end
        if (lowEvent) begin
            st_d.flag = 1'b1;
        end
        if (lowEvent && st_q.rstKey == supply_monitor_pkg::RESET_KEY) begin
            st_d.rstAct = 1'b1;
        end else if (st_q.rstAct && !st_q.result) begin
            st_d.rstAct = 1'b0;
        end
        if (st_d.rstAct) begin
            st_d.debugRun = supply_monitor_pkg::DEBUG_RUN_INIT;
            st_d.clock_divider_select = supply_monitor_pkg::CLK_DIV_INIT;
            st_d.clock_source_select = supply_monitor_pkg::CLK_SRC_INIT;
            st_d.lowSel = '0;
            st_d.mode = supply_monitor_pkg::MODE_CONTINUOUS;
            st_d.irqEn = 1'b0;
        end
        st_d.irq = st_d.flag && st_d.irqEn;
        st_d.rstReq = st_d.rstAct;
        st_d.awReady = !st_d.awHave && !st_d.bValid;
        st_d.wReady = !st_d.wHave && !st_d.bValid;
        st_d.arReady = !st_d.rValid;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.debugRun <= supply_monitor_pkg::DEBUG_RUN_INIT;
            st_q.thresh <= supply_monitor_pkg::THRESH_INIT;
        end else if (clockEnable) begin
            st_q <= st_d;
        end
    end

    assign awready = st_q.awReady;
    assign wready = st_q.wReady;
    assign bvalid = st_q.bValid;
    assign bresp = st_q.bResp;
    assign arready = st_q.arReady;
    assign rvalid = st_q.rValid;
    assign rresp = st_q.rResp;
    assign rdata = {16'h0000, st_q.rData};
    assign comparatorPower = st_q.power;
    assign thresholdLevel = st_q.thresh;
    assign clockSourceSelect = st_q.clock_source_select;
    assign clockDividerSelect = st_q.clock_divider_select;
    assign irqRequest = st_q.irq;
    assign resetRequest = st_q.rstReq;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence lowSeen;
        clockEnable && lowEvent;
    endsequence
    sequence lockedCtlWrite;
        clockEnable && doWrite && !unlocked && !lowEvent && !st_q.rstAct
            && st_q.wAddr == supply_monitor_pkg::ADDR_CONTROL;
    endsequence

    a_irq_gating: assert property (
        irqRequest == (st_q.flag && st_q.irqEn))
        else $error("irq request does not follow flag and enable");
    a_flag_set: assert property (lowSeen |=> st_q.flag)
        else $error("low detection did not set the flag");
    a_flag_sticky: assert property (
        st_q.flag && !(clockEnable && flagClr) |=> st_q.flag)
        else $error("flag dropped without a clear");
    a_flag_clear: assert property (
        clockEnable && flagClr && !lowEvent |=> !st_q.flag)
        else $error("write of one did not clear the flag");
    a_reset_issue: assert property (
        lowSeen ##0 st_q.rstKey == supply_monitor_pkg::RESET_KEY
        |=> resetRequest && st_q.flag)
        else $error("reset not issued with the flag");
    a_reset_key: assert property (
        lowSeen ##0 st_q.rstKey != supply_monitor_pkg::RESET_KEY
        ##0 !st_q.rstAct |=> !resetRequest)
        else $error("reset issued without the reset key");
    a_reset_state: assert property (
        resetRequest |-> st_q.mode == supply_monitor_pkg::MODE_CONTINUOUS
        && !st_q.irqEn && st_q.enable && st_q.lowSel == 2'h0)
        else $error("reset state fields wrong");
    a_reset_release: assert property (
        clockEnable && st_q.rstAct && !st_q.result && !lowEvent
        |=> !resetRequest)
        else $error("reset not released on normal supply");
    a_lock_ignore: assert property (lockedCtlWrite |=>
        $stable(st_q.mode) && $stable(st_q.enable) && $stable(st_q.thresh))
        else $error("locked control write took effect");
    a_halt_hold: assert property (
        clockEnable && !run && !doWrite |=> $stable(st_q.result))
        else $error("result changed while halted");
    a_result_cont: assert property (
        clockEnable && run && st_q.enable && contMode
        |=> st_q.result == $past(comparatorLow))
        else $error("continuous result not updated");
    a_count_need: assert property (
        lowEvent && !contMode |-> st_q.lowCnt == need - 4'h1)
        else $error("intermittent event before count reached");
endmodule : supply_monitor
`default_nettype wire

// File: rtl/supply_monitor_pkg.sv
`default_nettype none
package supply_monitor_pkg;
    localparam logic [7:0] ADDR_PROTECT = 8'h00;
    localparam logic [7:0] ADDR_CLOCK = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    localparam logic [15:0] UNLOCK_KEY = 16'h0096;
    localparam logic [3:0] RESET_KEY = 4'ha;
    localparam int unsigned DEBUG_RUN_BIT = 8;
    localparam int unsigned CLK_DIV_LSB = 4;
    localparam int unsigned CLK_SRC_LSB = 0;
    localparam int unsigned LOW_SEL_LSB = 13;
    localparam int unsigned THRESH_LSB = 8;
    localparam int unsigned RST_KEY_LSB = 4;
    localparam int unsigned MODE_LSB = 1;
    localparam int unsigned ENABLE_BIT = 0;
    localparam int unsigned RESULT_BIT = 8;
    localparam int unsigned FLAG_BIT = 0;
    localparam int unsigned IRQ_EN_BIT = 0;
    localparam logic DEBUG_RUN_INIT = 1'b1;
    localparam logic [4:0] THRESH_INIT = 5'h1e;
    localparam logic [2:0] CLK_DIV_INIT = 3'h0;
    localparam logic [1:0] CLK_SRC_INIT = 2'h0;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h0;
    localparam logic [1:0] MODE_PER_128 = 2'h1;
    localparam logic [1:0] MODE_PER_256 = 2'h2;
    localparam logic [8:0] LIMIT_128 = 9'h07f;
    localparam logic [8:0] LIMIT_256 = 9'h0ff;
    localparam logic [8:0] LIMIT_512 = 9'h1ff;
    localparam logic [8:0] WARM_TICKS = 9'h002;
    localparam logic [3:0] ONE_LOW = 4'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : supply_monitor_pkg
`default_nettype wire

// File: rtl/period_timer.sv
`timescale 1ns/10ps
`default_nettype none
module period_timer #(
    parameter int WIDTH = 9
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clockEnable,
    input wire logic tick,
    input wire logic clear,
    input wire logic [WIDTH-1:0] limit,
    output logic [WIDTH-1:0] count,
    output logic wrap
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } timer_state_type;

    timer_state_type st_q;
    timer_state_type st_d;

    always_comb begin
        st_d = st_q;
        if (clear) begin
            st_d.count = '0;
        end else if (tick) begin
            st_d.count = (st_q.count == limit) ? '0 : st_q.count + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else if (clockEnable) begin
            st_q <= st_d;
        end
    end

    assign count = st_q.count;
    assign wrap = tick && !clear && (st_q.count == limit);
endmodule : period_timer
`default_nettype wire

// File: tb/supply_model.sv
`timescale 1ns/10ps
`default_nettype none
module supply_model #(
    parameter int TICK_DIV = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic comparatorPower,
    input wire logic [4:0] thresholdLevel,
    input wire logic [4:0] supplyLevel,
    output logic detectorTick,
    output logic comparatorLow
);
    int divCount;
    // An unpowered comparator gives no usable answer, so it toggles.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            divCount <= 0;
            detectorTick <= 1'b0;
            comparatorLow <= 1'b0;
        end else begin
            divCount <= (divCount == TICK_DIV - 1) ? 0 : divCount + 1;
            detectorTick <= (divCount == 0);
            comparatorLow <= comparatorPower ?
                (supplyLevel < thresholdLevel) : !comparatorLow;
        end
    end
endmodule : supply_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [31:0] A_KEY = 32'(supply_monitor_pkg::ADDR_PROTECT);
    localparam logic [31:0] A_CLK = 32'(supply_monitor_pkg::ADDR_CLOCK);
    localparam logic [31:0] A_CTL = 32'(supply_monitor_pkg::ADDR_CONTROL);
    localparam logic [31:0] A_STA = 32'(supply_monitor_pkg::ADDR_STATUS);
    localparam logic [31:0] A_IEN = 32'(supply_monitor_pkg::ADDR_IRQ_EN);
    localparam logic [31:0] A_BAD = 32'h0000_0014;
    localparam logic [31:0] KEY = 32'(supply_monitor_pkg::UNLOCK_KEY);
    localparam logic [3:0] RKEY = supply_monitor_pkg::RESET_KEY;
    localparam logic [1:0] ERR = supply_monitor_pkg::RESP_SLVERR;
    localparam logic [4:0] LO = 5'h00;
    localparam logic [4:0] HI = supply_monitor_pkg::THRESH_INIT;
    localparam int TD = 4;
    logic clock, reset_n, sleepMode, sleepClockStop, debugMode;
    logic detectorTick, comparatorLow, awvalid, wvalid, bready;
    logic arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic comparatorPower, irqRequest, resetRequest, run;
    logic [31:0] awaddr, wdata, araddr, rdata, r;
    logic [1:0] bresp, rresp, clockSourceSelect, md;
    logic [2:0] clockDividerSelect;
    logic [4:0] thresholdLevel, supplyLevel;
    logic [33:0] readQ[$];
    logic [1:0] writeQ[$];
    int fail_count = 0;
    int n_compared = 0;
    int took, cyc;
    logic [31:0] seed = 32'h392c;

    supply_monitor #(.TIMER_WIDTH(9)) supply_monitor_inst (
        .clock(clock), .reset_n(reset_n), .clockEnable(1'b1),
        .detectorTick(detectorTick), .comparatorLow(comparatorLow),
        .sleepMode(sleepMode), .sleepClockStop(sleepClockStop),
        .debugMode(debugMode), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'h3), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .comparatorPower(comparatorPower), .thresholdLevel(thresholdLevel),
        .clockSourceSelect(clockSourceSelect),
        .clockDividerSelect(clockDividerSelect),
        .irqRequest(irqRequest), .resetRequest(resetRequest));
    supply_model #(.TICK_DIV(TD)) supply_model_inst (
        .clock(clock), .reset_n(reset_n), .comparatorPower(comparatorPower),
        .thresholdLevel(thresholdLevel), .supplyLevel(supplyLevel),
        .detectorTick(detectorTick), .comparatorLow(comparatorLow));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [31:0] ctl(logic [1:0] lc, logic [3:0] k,
            logic [1:0] m, logic en);
        return {17'h0, lc, HI, k, 1'b0, m, en};
    endfunction : ctl

    task automatic check(string name, logic [33:0] seen, logic [33:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic timeout(string name);
        fail_count++;
        $display("MISMATCH %s expected answer seen none", name);
        results();
    endtask : timeout

    // The result queues are checked where the bus handshakes complete.
    always @(posedge clock) begin
        if (rvalid === 1'b1 && rready === 1'b1)
            check("read", {rresp, rdata}, readQ.pop_front());
        if (bvalid === 1'b1 && bready === 1'b1)
            check("bresp", 34'(bresp), 34'(writeQ.pop_front()));
    end

    task automatic wr(logic [31:0] a, logic [31:0] d, logic [1:0] e = 2'h0);
        int n;
        writeQ.push_back(e);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) timeout("write");
    endtask : wr

    task automatic rd(logic [31:0] a, logic [31:0] d, logic [1:0] e = 2'h0);
        int n;
        readQ.push_back({e, d});
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) timeout("read");
    endtask : rd

    // Waiting on a bounded loop keeps a dead design from hanging the run.
    task automatic waitSig(logic rst, logic val, int lim);
        for (took = 0; took < lim; took++) begin
            @(posedge clock);
            if ((rst ? resetRequest : irqRequest) === val) break;
        end
        if (took == lim) timeout(rst ? "resetRequest" : "irqRequest");
    endtask : waitSig

    initial begin
        reset_n = 1'b0;
        {sleepMode, sleepClockStop, debugMode} = 3'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, wdata, araddr} = 96'h0;
        supplyLevel = HI;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        rd(A_CLK, 32'h100);
        rd(A_CTL, ctl(0, 0, 0, 0));
        wr(A_CTL, xs() | 32'h1);
        wr(A_IEN, xs() | 32'h1);
        rd(A_CTL, ctl(0, 0, 0, 0));
        rd(A_IEN, 32'h0);
        rd(A_BAD, 32'h0, ERR);
        wr(A_BAD, xs(), ERR);
        $display("test protection done");
        wr(A_KEY, KEY);
        wr(A_IEN, 32'h1);
        wr(A_CTL, ctl(0, 0, 0, 1));
        repeat (20) @(posedge clock);
        check("power", 34'(comparatorPower), 34'h1);
        rd(A_STA, 32'h0);
        supplyLevel <= LO;
        waitSig(1'b0, 1'b1, 40);
        rd(A_STA, 32'h101);
        supplyLevel <= HI;
        repeat (20) @(posedge clock);
        rd(A_STA, 32'h1);
        wr(A_STA, 32'h0);
        rd(A_STA, 32'h1);
        wr(A_IEN, 32'h0);
        rd(A_STA, 32'h1);
        check("irqRequest", 34'(irqRequest), 34'h0);
        wr(A_STA, 32'h1);
        rd(A_STA, 32'h0);
        $display("test continuous done");
        for (int i = 0; i < 4; i++) begin
            wr(A_CLK, (i == 0) ? 32'h0 : 32'h100);
            debugMode <= (i < 2);
            sleepMode <= (i >= 2);
            sleepClockStop <= (i == 2);
            run = (i % 2 == 1);
            supplyLevel <= LO;
            repeat (40) @(posedge clock);
            rd(A_STA, run ? 32'h101 : 32'h0);
            debugMode <= 1'b0;
            sleepMode <= 1'b0;
            repeat (40) @(posedge clock);
            rd(A_STA, 32'h101);
            supplyLevel <= HI;
            repeat (20) @(posedge clock);
            wr(A_STA, 32'h1);
        end
        $display("test clock halts done");
        wr(A_IEN, 32'h1);
        for (int i = 0; i < 4; i++) begin
            md = (i == 0) ? 2'h1 : 2'(i);
            wr(A_CTL, ctl(0, 0, md, 0));
            wr(A_STA, 32'h1);
            supplyLevel <= LO;
            wr(A_CTL, ctl(2'(i), 0, md, 1));
            cyc = TD * (64 << md);
            waitSig(1'b0, 1'b1, (cyc << i) + cyc / 2);
            check("lowCount", 34'(took >= (cyc << i) - cyc / 2), 34'h1);
            check("resetRequest", 34'(resetRequest), 34'h0);
            rd(A_STA, 32'h101);
            supplyLevel <= HI;
        end
        $display("test intermittent done");
        wr(A_CLK, 32'h031);
        check("divider", 34'(clockDividerSelect), 34'h3);
        wr(A_CTL, ctl(0, 0, 2'h1, 0));
        wr(A_STA, 32'h1);
        supplyLevel <= LO;
        wr(A_CTL, ctl(2'h1, RKEY, 2'h1, 1));
        waitSig(1'b1, 1'b1, 3 * TD * 128);
        check("resetDelay", 34'(took >= TD * 192), 34'h1);
        rd(A_STA, 32'h101);
        rd(A_CLK, 32'h100);
        rd(A_CTL, ctl(0, RKEY, 0, 1));
        rd(A_IEN, 32'h0);
        check("irqRequest", 34'(irqRequest), 34'h0);
        check("source", 34'(clockSourceSelect), 34'h0);
        check("threshold", 34'(thresholdLevel), 34'(HI));
        supplyLevel <= HI;
        waitSig(1'b1, 1'b0, 40);
        r = xs();
        wr(A_KEY, (r[15:0] == KEY[15:0]) ? 32'h0 : r);
        wr(A_CTL, ctl(0, 0, 0, 0));
        rd(A_CTL, ctl(0, RKEY, 0, 1));
        wr(A_KEY, KEY);
        wr(A_CTL, ctl(0, RKEY, 0, 0));
        rd(A_CTL, ctl(0, RKEY, 0, 0));
        check("power", 34'(comparatorPower), 34'h0);
        wr(A_KEY, 32'h0);
        $display("test reset state done");
        results();
    end
endmodule : tb
`default_nettype wire
